// file: muxed_addr_data_bus_bench.sv
// self-checking bench for the multiplexed bus controller with a peripheral model
`default_nettype none
module muxed_addr_data_bus_bench
   import mxb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0, rst_i = 1'b1, address_phase_extend_i = 1'b0, slow = 1'b0;
   logic req_valid_i = 1'b0, req_write_i = 1'b0, wait_n_i, req_ready_o, rsp_valid_o;
   logic address_hold_strobe_n_o, read_strobe_n_o, upper_byte_write_strobe_n_o;
   logic lower_byte_write_strobe_n_o, cycle_start_signal_n_o, read_write_o;
   logic [7:0] area_multiplex_enable_i = 8'h78, area_width_high_bit_i = 8'hF7;
   logic [7:0] area_width_low_bit_i = 8'hFF, area_three_state_i = 8'h60;
   logic [7:0] area_wait_pin_enable_i = 8'h40, area_read_negate_late_i = 8'h00;
   logic [7:0] area_cs_lead_ext_i = 8'h20, area_cs_trail_ext_i = 8'h40;
   logic [7:0] area_chip_select_n_o;
   logic [23:0] area_wait_count_i = 24'h078000, req_addr_i = 24'h0, addr_o;
   logic [15:0] req_wdata_i = 16'h0, rsp_rdata_o, ad_i, ad_o, ad_oe_o, per_ad, rd, ad_seen;
   logic [2:0] req_area_i = 3'h0;
   logic [1:0] req_byte_en_i = 2'h0;
   int miscompares = 0, n_checks = 0, cyc = 0, rd_lo = 0, lat, lat2;
   mxb_ctrl u_dut (.core_clk_i, .rst_i, .area_multiplex_enable_i, .area_width_high_bit_i,
      .area_width_low_bit_i, .area_three_state_i, .area_wait_count_i, .area_wait_pin_enable_i,
      .area_read_negate_late_i, .area_cs_lead_ext_i, .area_cs_trail_ext_i,
      .address_phase_extend_i, .req_valid_i, .req_area_i, .req_write_i, .req_addr_i,
      .req_wdata_i, .req_byte_en_i, .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .ad_i, .ad_o,
      .ad_oe_o, .addr_o, .area_chip_select_n_o, .address_hold_strobe_n_o, .read_strobe_n_o,
      .upper_byte_write_strobe_n_o, .lower_byte_write_strobe_n_o, .cycle_start_signal_n_o,
      .read_write_o, .wait_n_i);
   mxb_periph_model u_per (.core_clk_i, .slow_i(slow), .bus_i(ad_i),
      .hold_n_i(address_hold_strobe_n_o), .rd_n_i(read_strobe_n_o),
      .hi_wr_n_i(upper_byte_write_strobe_n_o), .lo_wr_n_i(lower_byte_write_strobe_n_o),
      .per_ad_o(per_ad), .wait_n_o(wait_n_i));
   // wire level: controller wins where it enables, peripheral elsewhere
   assign ad_i = (ad_oe_o & ad_o) | (~ad_oe_o & per_ad);
   initial forever #4 core_clk_i = ~core_clk_i;
   always @(negedge core_clk_i) if (!read_strobe_n_o) rd_lo++;
   always @(negedge core_clk_i) if (!address_hold_strobe_n_o) ad_seen = ad_o;
   always @(posedge core_clk_i)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // one transfer; lat counts cycles from the take edge to the answer
   task automatic xfer(input logic [2:0] a, input logic w, input logic [23:0] ad,
      input logic [15:0] wd, input logic [1:0] be);
      chk("ready", 1'b1, req_ready_o);
      {req_area_i, req_write_i, req_addr_i, req_wdata_i, req_byte_en_i} = {a, w, ad, wd, be};
      req_valid_i = 1'b1;
      rd_lo = 0;
      @(negedge core_clk_i);
      req_valid_i = 1'b0;
      lat = 1;
      while (rsp_valid_o !== 1'b1 && lat < 40)
      begin
         @(negedge core_clk_i);
         lat++;
      end
      rd = rsp_rdata_o;
      @(negedge core_clk_i);
   endtask : xfer
   task automatic t_w16;
      xfer(3'h3, 1'b1, 24'h123456, 16'hA5C3, 2'h3);
      chk("lat_w16", 5, lat);
      chk("addr16", 16'h3456, ad_seen);
      xfer(3'h3, 1'b0, 24'h123456, 16'h0000, 2'h3);
      chk("data16", 16'hA5C3, rd);
      $display("t_w16 done");
   endtask : t_w16
   task automatic t_w8;
      xfer(3'h4, 1'b1, 24'h000047, 16'h3C96, 2'h1);
      chk("addr8", 8'h47, ad_seen[7:0]);
      xfer(3'h4, 1'b0, 24'h000047, 16'h0000, 2'h1);
      chk("data8", 16'h0096, rd);
      $display("t_w8 done");
   endtask : t_w8
   task automatic t_wait;
      address_phase_extend_i = 1'b1;
      xfer(3'h5, 1'b1, 24'h000055, 16'h005A, 2'h1);
      chk("lat_wait", 5 + 1 + 1 + 1 + 7, lat);
      xfer(3'h5, 1'b0, 24'h000055, 16'h0000, 2'h1);
      chk("data_wait", 16'h005A, rd);
      address_phase_extend_i = 1'b0;
      $display("t_wait done");
   endtask : t_wait
   task automatic t_rdneg;
      xfer(3'h3, 1'b0, 24'h123456, 16'h0000, 2'h3);
      lat2 = rd_lo;
      area_read_negate_late_i[3] = 1'b1;
      xfer(3'h3, 1'b0, 24'h123456, 16'h0000, 2'h3);
      chk("rd_late", lat2 + 1, rd_lo);
      chk("data_late", 16'hA5C3, rd);
      area_read_negate_late_i[3] = 1'b0;
      $display("t_rdneg done");
   endtask : t_rdneg
   task automatic t_pin;
      xfer(3'h6, 1'b1, 24'h000066, 16'h0069, 2'h1);
      xfer(3'h6, 1'b0, 24'h000066, 16'h0000, 2'h1);
      lat2 = lat;
      slow = 1'b1;
      xfer(3'h6, 1'b0, 24'h000066, 16'h0000, 2'h1);
      chk("data_slow", 16'h0069, rd);
      chk("slow_longer", 1'b1, lat > lat2);
      xfer(3'h6, 1'b0, 24'h000066, 16'h0000, 2'h1);
      chk("data_b2b", 16'h0069, rd);
      slow = 1'b0;
      $display("t_pin done");
   endtask : t_pin
   task automatic t_refuse;
      xfer(3'h7, 1'b0, 24'h000077, 16'h0000, 2'h1);
      chk("no_rsp7", 40, lat);
      area_multiplex_enable_i = 8'h04;
      xfer(3'h2, 1'b0, 24'h000022, 16'h0000, 2'h1);
      chk("no_rsp2", 40, lat);
      chk("hold_idle", 1'b1, address_hold_strobe_n_o);
      area_multiplex_enable_i = 8'h78;
      $display("t_refuse done");
   endtask : t_refuse
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   initial
   begin
      repeat (16) @(negedge core_clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      t_w16();
      t_w8();
      t_wait();
      t_rdneg();
      t_pin();
      t_refuse();
      report_and_stop();
   end
endmodule : muxed_addr_data_bus_bench
`default_nettype wire

// file: mxb_ctrl.sv
// multiplexed address/data bus cycle controller for external areas 3 to 7
`default_nettype none
module mxb_ctrl
   import mxb_pkg::*;
(
   input  wire logic                          core_clk_i,
   input  wire logic                          rst_i,
   input  wire logic [MXB_AREAS-1:0]          area_multiplex_enable_i,
   input  wire logic [MXB_AREAS-1:0]          area_width_high_bit_i,
   input  wire logic [MXB_AREAS-1:0]          area_width_low_bit_i,
   input  wire logic [MXB_AREAS-1:0]          area_three_state_i,
   input  wire logic [MXB_AREAS*MXB_WAIT_W-1:0] area_wait_count_i,
   input  wire logic [MXB_AREAS-1:0]          area_wait_pin_enable_i,
   input  wire logic [MXB_AREAS-1:0]          area_read_negate_late_i,
   input  wire logic [MXB_AREAS-1:0]          area_cs_lead_ext_i,
   input  wire logic [MXB_AREAS-1:0]          area_cs_trail_ext_i,
   input  wire logic                          address_phase_extend_i,
   input  wire logic                          req_valid_i,
   input  wire logic [2:0]                    req_area_i,
   input  wire logic                          req_write_i,
   input  wire logic [MXB_ADDR_W-1:0]         req_addr_i,
   input  wire logic [MXB_DATA_W-1:0]         req_wdata_i,
   input  wire logic [1:0]                    req_byte_en_i,
   output logic                               req_ready_o,
   output logic                               rsp_valid_o,
   output logic [MXB_DATA_W-1:0]              rsp_rdata_o,
   input  wire logic [MXB_DATA_W-1:0]         ad_i,
   output logic [MXB_DATA_W-1:0]              ad_o,
   output logic [MXB_DATA_W-1:0]              ad_oe_o,
   output logic [MXB_ADDR_W-1:0]              addr_o,
   output logic [MXB_AREAS-1:0]               area_chip_select_n_o,
   output logic                               address_hold_strobe_n_o,
   output logic                               read_strobe_n_o,
   output logic                               upper_byte_write_strobe_n_o,
   output logic                               lower_byte_write_strobe_n_o,
   output logic                               cycle_start_signal_n_o,
   output logic                               read_write_o,
   input  wire logic                          wait_n_i
);
   mxb_state_type state;
   mxb_state_type next_state;
   logic [2:0]            area;
   logic                  wr;
   logic [MXB_DATA_W-1:0] wdata;
   logic [1:0]            ben;
   logic                  wide;
   logic                  any_mux;
   logic                  wait_n_s;
   logic                  wait_done;
   logic                  load_wait;
   logic                  pin_wait;
   logic [MXB_AREAS-1:0]  mux_ok;
   logic [MXB_WAIT_W-1:0] wcount;
   logic                  req_take;

   mxb_sync u_wait_sync (
      .core_clk_i  (core_clk_i),
      .rst_i       (rst_i),
      .async_i     (wait_n_i),
      .reset_val_i (1'b1),
      .sync_o      (wait_n_s)
   );

   // only areas 3 to 7 may be multiplexed
   genvar g;
   generate
      for (g = 0; g < MXB_AREAS; g++)
      begin : g_area
         assign mux_ok[g] = (g >= MXB_FIRST_AREA) && area_multiplex_enable_i[g]; // R1
      end
   endgenerate

   assign any_mux   = |mux_ok; // R10
   assign wcount    = area_three_state_i[area] ? area_wait_count_i[area*MXB_WAIT_W +: MXB_WAIT_W]
                                               : MXB_WAIT_ZERO; // R19
   assign req_take  = (state == MXB_IDLE) && req_valid_i && mux_ok[req_area_i] && !rsp_valid_o;
   assign load_wait = (state == MXB_DATA_ONE);
   // wait pin only sampled in the wait window, never in the address phase
   assign pin_wait  = area_wait_pin_enable_i[area] && area_three_state_i[area] && !wait_n_s; // R11 R12

   mxb_wait_ctr u_wait (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .load_i     (load_wait),
      .count_i    (wcount),
      // counting starts in the second data state so the window is exactly the programmed length
      .step_i     ((state == MXB_DATA_TWO) || (state == MXB_DATA_WAIT)),
      .done_o     (wait_done)
   );

   always_comb
   begin
      next_state = state;
      case (state)
         MXB_IDLE:
            if (req_take)
               next_state = area_cs_lead_ext_i[req_area_i] ? MXB_CS_LEAD : MXB_ADDR_ONE; // R14
         MXB_CS_LEAD:
            next_state = MXB_ADDR_ONE;
         MXB_ADDR_ONE:
            next_state = address_phase_extend_i ? MXB_ADDR_EXT : MXB_ADDR_TWO; // R8
         MXB_ADDR_EXT:
            next_state = MXB_ADDR_TWO;
         MXB_ADDR_TWO:
            next_state = MXB_DATA_ONE; // R7 R12
         MXB_DATA_ONE:
            next_state = MXB_DATA_TWO;
         MXB_DATA_TWO:
            if (!area_three_state_i[area])
               next_state = area_cs_trail_ext_i[area] ? MXB_CS_TRAIL : MXB_IDLE;
            else if (wcount != MXB_WAIT_ZERO || pin_wait)
               next_state = MXB_DATA_WAIT; // R19
            else
               next_state = MXB_DATA_THREE;
         MXB_DATA_WAIT:
            if (wait_done && !pin_wait)
               next_state = MXB_DATA_THREE; // R11
         MXB_DATA_THREE:
            next_state = area_cs_trail_ext_i[area] ? MXB_CS_TRAIL : MXB_IDLE; // R14 R15
         MXB_CS_TRAIL:
            next_state = MXB_IDLE;
         default:
            next_state = MXB_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         state <= MXB_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         area  <= MXB_AREA_NONE;
         wr    <= 1'b0;
         wdata <= '0;
         ben   <= 2'h0;
         wide  <= 1'b0;
      end
      else if (req_take)
      begin
         area  <= req_area_i;
         wr    <= req_write_i;
         wdata <= req_wdata_i;
         ben   <= req_byte_en_i;
         wide  <= !area_width_high_bit_i[req_area_i] && area_width_low_bit_i[req_area_i]; // R2 R3
      end
   end

   // address- and data-phase state decodes, used for strobe shaping
   logic in_addr;
   logic in_data;
   logic last_data;
   logic next_in_addr;
   logic next_in_data;
   logic next_busy;
   assign next_in_addr = (next_state == MXB_ADDR_ONE) || (next_state == MXB_ADDR_EXT)
                       || (next_state == MXB_ADDR_TWO);
   assign next_in_data = (next_state == MXB_DATA_ONE) || (next_state == MXB_DATA_TWO)
                       || (next_state == MXB_DATA_WAIT) || (next_state == MXB_DATA_THREE);
   assign next_busy    = (next_state != MXB_IDLE);
   assign in_addr      = (state == MXB_ADDR_ONE) || (state == MXB_ADDR_EXT)
                       || (state == MXB_ADDR_TWO);
   assign in_data      = (state == MXB_DATA_ONE) || (state == MXB_DATA_TWO)
                       || (state == MXB_DATA_WAIT) || (state == MXB_DATA_THREE);
   assign last_data    = (state == MXB_DATA_THREE)
                       || (state == MXB_DATA_TWO && !area_three_state_i[area]);

   // outputs are registered from the next state so each pin is a flop
   logic [MXB_DATA_W-1:0] addr_word;
   logic [2:0] next_area;
   assign next_area = req_take ? req_area_i : area;
   logic next_wide;
   assign next_wide = req_take ? (!area_width_high_bit_i[req_area_i]
                                  && area_width_low_bit_i[req_area_i]) : wide;
   logic [MXB_ADDR_W-1:0] addr_hold;
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         addr_hold <= '0;
      else if (req_take)
         addr_hold <= req_addr_i;
   end
   assign addr_word = next_wide ? addr_hold[MXB_DATA_W-1:0]
                                : {8'h00, addr_hold[MXB_LOW_MSB:0]}; // R4 R5

   // shared pins: address in address phase, write data in data phase
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         ad_o    <= '0;
         ad_oe_o <= '0;
      end
      else if (next_in_addr)
      begin
         ad_o    <= req_take ? (next_wide ? req_addr_i[MXB_DATA_W-1:0]
                                          : {8'h00, req_addr_i[MXB_LOW_MSB:0]}) : addr_word;
         ad_oe_o <= next_wide ? 16'hFFFF : 16'h00FF; // R4 R5
      end
      else if (next_in_data && wr)
      begin
         ad_o    <= wdata; // R20
         ad_oe_o <= next_wide ? 16'hFFFF : 16'h00FF;
      end
      else
      begin
         ad_o    <= '0;
         ad_oe_o <= '0; // R20 R21
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         addr_o <= '0;
      else if (req_take)
         addr_o <= req_addr_i; // R6
   end

   // chip select covers extension cycles as well as the cycle itself
   generate
      for (g = 0; g < MXB_AREAS; g++)
      begin : g_cs
         always_ff @(posedge core_clk_i)
         begin
            if (rst_i)
               area_chip_select_n_o[g] <= 1'b1;
            else
               area_chip_select_n_o[g] <= !(next_busy && next_area == g); // R16 R14
         end
      end
   endgenerate

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         address_hold_strobe_n_o <= 1'b1;
      else if (any_mux)
         address_hold_strobe_n_o <= !next_in_addr; // R9 R10 R20
      else
         address_hold_strobe_n_o <= 1'b1;
   end

   // late negation holds the read strobe into the trailing state
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         read_strobe_n_o <= 1'b1;
      else if (!wr && next_in_data)
         read_strobe_n_o <= 1'b0; // R18
      // one extra low cycle also when the bus goes straight back to idle
      else if (!wr && last_data && area_read_negate_late_i[area])
         read_strobe_n_o <= 1'b0; // R13
      else
         read_strobe_n_o <= 1'b1;
   end

   // write strobes only from second data state, after data has settled
   logic next_wr_win;
   assign next_wr_win = wr && next_in_data && (next_state != MXB_DATA_ONE)
                      && !(state == MXB_DATA_THREE);
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         upper_byte_write_strobe_n_o <= 1'b1;
         lower_byte_write_strobe_n_o <= 1'b1;
      end
      else
      begin
         upper_byte_write_strobe_n_o <= !(next_wr_win && wide && ben[1]); // R17
         lower_byte_write_strobe_n_o <= !(next_wr_win && ben[0]); // R17
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cycle_start_signal_n_o <= 1'b1;
         read_write_o           <= 1'b1;
      end
      else
      begin
         cycle_start_signal_n_o <= !(next_state == MXB_ADDR_ONE); // R18
         read_write_o           <= next_busy ? !(req_take ? req_write_i : wr) : 1'b1; // R18
      end
   end

   // read data captured at the end of the last data state
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         rsp_valid_o <= 1'b0;
         rsp_rdata_o <= '0;
      end
      else
      begin
         rsp_valid_o <= in_data && last_data;
         if (in_data && last_data && !wr)
            rsp_rdata_o <= wide ? ad_i : {8'h00, ad_i[MXB_LOW_MSB:0]}; // R4 R5
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         req_ready_o <= 1'b0;
      else
         req_ready_o <= (next_state == MXB_IDLE) && !req_take;
   end
endmodule : mxb_ctrl
`default_nettype wire

// file: mxb_ctrl_monitor.sv
// pin-level assertion checker for the multiplexed bus controller
`default_nettype none
module mxb_ctrl_monitor
   import mxb_pkg::*;
(
   input wire logic                  core_clk_i,
   input wire logic                  rst_i,
   input wire logic                  address_phase_extend_i,
   input wire logic [MXB_AREAS-1:0]  area_multiplex_enable_i,
   input wire logic [MXB_DATA_W-1:0] ad_o,
   input wire logic [MXB_DATA_W-1:0] ad_oe_o,
   input wire logic [MXB_ADDR_W-1:0] addr_o,
   input wire logic [MXB_AREAS-1:0]  area_chip_select_n_o,
   input wire logic                  address_hold_strobe_n_o,
   input wire logic                  read_strobe_n_o,
   input wire logic                  upper_byte_write_strobe_n_o,
   input wire logic                  lower_byte_write_strobe_n_o,
   input wire logic                  cycle_start_signal_n_o,
   input wire logic                  read_write_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   wire logic h = address_hold_strobe_n_o;
   wire logic r = read_strobe_n_o;
   wire logic u = upper_byte_write_strobe_n_o;
   wire logic l = lower_byte_write_strobe_n_o;
   property p_hold2; $fell(h) && !address_phase_extend_i |=> !h ##1 h; endproperty
   a_hold2: assert property (p_hold2) else $error("hold not two cycles");
   property p_hold3; $fell(h) && address_phase_extend_i |=> !h[*2] ##1 h; endproperty
   a_hold3: assert property (p_hold3) else $error("hold not three cycles");
   property p_start; $fell(cycle_start_signal_n_o) |=> cycle_start_signal_n_o; endproperty
   a_start: assert property (p_start) else $error("cycle start not a pulse");
   property p_addr; $fell(h) |-> ad_oe_o[7:0] == 8'hFF && ad_o[7:0] == addr_o[7:0]; endproperty
   a_addr: assert property (p_addr) else $error("address not on shared pins");
   property p_cs;
      !h |-> area_chip_select_n_o[7:3] != 5'h1F && area_chip_select_n_o[2:0] == 3'h7;
   endproperty
   a_cs: assert property (p_cs) else $error("no area select during hold");
   property p_sep; !r || !u || !l |-> h; endproperty
   a_sep: assert property (p_sep) else $error("hold overlaps data strobe");
   property p_rd; !r |-> read_write_o && ad_oe_o == 16'h0000; endproperty
   a_rd: assert property (p_rd) else $error("read strobe while driving");
   property p_up; !u |-> !read_write_o && ad_oe_o == 16'hFFFF; endproperty
   a_up: assert property (p_up) else $error("upper strobe without upper data");
   property p_lo; !l |-> !read_write_o && ad_oe_o[7:0] == 8'hFF; endproperty
   a_lo: assert property (p_lo) else $error("lower strobe without lower data");
   property p_nomux; area_multiplex_enable_i[7:3] == 5'h00 |-> h; endproperty
   a_nomux: assert property (p_nomux) else $error("hold without multiplexed area");
   c_ext: cover property (address_phase_extend_i && $fell(h));
   c_read: cover property ($fell(r));
   c_write: cover property ($fell(u));
endmodule : mxb_ctrl_monitor
bind mxb_ctrl mxb_ctrl_monitor u_mon (.core_clk_i, .rst_i, .address_phase_extend_i,
   .area_multiplex_enable_i, .ad_o, .ad_oe_o, .addr_o, .area_chip_select_n_o,
   .address_hold_strobe_n_o, .read_strobe_n_o, .upper_byte_write_strobe_n_o,
   .lower_byte_write_strobe_n_o, .cycle_start_signal_n_o, .read_write_o);
`default_nettype wire

// file: mxb_periph_model.sv
// behavioural peripheral on the multiplexed address/data pins
`default_nettype none
module mxb_periph_model
   import mxb_pkg::*;
(
   input  wire logic                  core_clk_i,
   input  wire logic                  slow_i,
   input  wire logic [MXB_DATA_W-1:0] bus_i,
   input  wire logic                  hold_n_i,
   input  wire logic                  rd_n_i,
   input  wire logic                  hi_wr_n_i,
   input  wire logic                  lo_wr_n_i,
   output logic      [MXB_DATA_W-1:0] per_ad_o,
   output logic                       wait_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] mem [16];
   logic [15:0] lat;
   logic [15:0] last = 16'h0000;
   logic [2:0]  cnt = 3'h0;
   logic        hold_q = 1'b1;
   always @(posedge core_clk_i)
   begin
      if (!hold_n_i) lat <= bus_i;
      if (!hi_wr_n_i) mem[lat[3:0]][15:8] <= bus_i[15:8];
      if (!lo_wr_n_i) mem[lat[3:0]][7:0] <= bus_i[7:0];
      if (!rd_n_i) last <= mem[lat[3:0]];
      hold_q <= hold_n_i;
      // slow mode keeps wait low five cycles from the start of the hold strobe
      if (hold_q && !hold_n_i && slow_i) cnt <= 3'h4;
      else if (cnt != 3'h0) cnt <= cnt - 3'h1;
   end
   // released lines show the inverse so a stale value never matches
   assign per_ad_o = rd_n_i ? ~last : mem[lat[3:0]];
   // wait drops with the hold strobe so the synchroniser delay is covered
   assign wait_n_o = !(slow_i && (!hold_n_i || cnt != 3'h0));
endmodule : mxb_periph_model
`default_nettype wire

// file: mxb_pkg.sv
// package of constants and types for the multiplexed address/data bus controller
// What this block does
// R1 - each area 3 to 7 enters multiplexed mode through its own enable bit
// R2 - each multiplexed area selects an 8-bit or 16-bit bus width
// R3 - width high 1 with low 1 is 8-bit; high 0 with low 1 is 16-bit
// R4 - 8-bit space drives address 7..0 then data 7..0 on low pins only
// R5 - 16-bit space drives address 15..0 then data 15..0 on all pins
// R6 - the full access address appears on the dedicated address pins
// R7 - a cycle is an address phase followed by a basic-style data phase
// R8 - address phase is two cycles, three when address extension is set
// R9 - address hold strobe is asserted during the address phase
// R10 - shared pin is address strobe until any area is multiplexed, then hold only; here the pin stays high while no area is multiplexed
// R11 - programmed and pin waits stretch the data phase as on basic cycles
// R12 - no wait setting or wait pin lengthens the address phase
// R13 - read strobe negation timing follows the read negation setting
// R14 - optional chip-select extension cycles before and after the cycle
// R15 - software should enable trailing extension for back-to-back slow-hold reads
// R16 - chip select of area n is asserted while that multiplexed area is accessed
// R17 - upper and lower byte write strobes mark valid data bytes on writes
// R18 - cycle start marks each cycle, direction is driven, read strobe on reads
// R19 - programmed waits insert 0 to 7 cycles between second and third data states
// R20 - address hold is negated before write data or read release on shared pins
// R21 - peripheral latches address on hold, drives read data only under read strobe
`default_nettype none
package mxb_pkg;
   localparam int MXB_AREAS      = 8;
   localparam int MXB_FIRST_AREA = 3;
   localparam int MXB_DATA_W     = 16;
   localparam int MXB_ADDR_W     = 24;
   localparam int MXB_WAIT_W     = 3;
   localparam int MXB_LOW_MSB    = 7;
   localparam logic [2:0] MXB_AREA_NONE = 3'h0;
   localparam logic [MXB_WAIT_W-1:0] MXB_WAIT_ZERO = 3'h0;
   typedef enum logic [3:0] {
      MXB_IDLE,
      MXB_CS_LEAD,
      MXB_ADDR_ONE,
      MXB_ADDR_EXT,
      MXB_ADDR_TWO,
      MXB_DATA_ONE,
      MXB_DATA_TWO,
      MXB_DATA_WAIT,
      MXB_DATA_THREE,
      MXB_CS_TRAIL
   } mxb_state_type;
endpackage : mxb_pkg
`default_nettype wire

// file: mxb_sync.sv
// three-flop input synchroniser with agreement filter
`default_nettype none
module mxb_sync
   import mxb_pkg::*;
(
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   input  wire logic reset_val_i,
   output var  logic sync_o
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge core_clk_i)
   begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
   end
   // a change counts only once the second and third flops agree
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         sync_o <= reset_val_i;
      else if (s2 == s3)
         sync_o <= s3;
   end
endmodule : mxb_sync
`default_nettype wire

// file: mxb_wait_ctr.sv
// down counter for programmed data-phase waits
`default_nettype none
module mxb_wait_ctr
   import mxb_pkg::*;
(
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  load_i,
   input  wire logic [MXB_WAIT_W-1:0] count_i,
   input  wire logic                  step_i,
   output var  logic                  done_o
);
   logic [MXB_WAIT_W-1:0] left;
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         left <= MXB_WAIT_ZERO;
      else if (load_i)
         left <= count_i;
      else if (step_i && left != MXB_WAIT_ZERO)
         left <= left - 3'h1;
   end
   assign done_o = (left == MXB_WAIT_ZERO);
endmodule : mxb_wait_ctr
`default_nettype wire
